// *** rtl/net_adaptor_pkg.sv ***
// constants shared by the network adaptor i/o register block
// Behaviour
// R1 - nine address bits decoded; bits 8-6 pick group, 5-0 go to group
// R2 - group 7 reads return fixed identifier; writes acknowledged, no effect
// R3 - group 6 reads return station rom byte by bits 4-0; writes ignored
// R4 - rom: address, checksum, reversed copy, duplicate, then alternating pattern
// R5 - group 4 maps 64 serial registers; upper 24 bits read zero, ignored
// R6 - host spaces serial controller accesses at least 450 ns apart
// R7 - group 5 reads status word; writes load only control field
// R8 - snapshot ethernet status on its interrupt and on status register reads
// R9 - consume pointer steps before receive flag; produce steps on length write
// R10 - fifo empty when pointers equal, full when produce plus one equals consume
// R11 - control bits 7-4 read/write, cleared by reset
// R12 - lane sequence bit picks byte order for send and receive
// R13 - transceiver off loops transmitter to receiver
// R14 - send enable sends one packet, flags, then waits for enable low
// R15 - receive runs only when enabled and descriptor fifo not empty
// R16 - interrupt line asserted while any flag bit set
// R17 - status read clears flags unless address bit zero set; reset clears
// R18 - send flag set when packet sent or aborted
// R19 - software watchdog of 3 seconds clears send enable if hung
// R20 - receive flag set per copied packet; completions merge
// R21 - bad bus parity on sampled cycles sets parity flag; parity generated
// R22 - serial flag follows pin; read clears it only with pin inactive
// R23 - status word layout and flag bit order fixed
package net_adaptor_pkg;
	// register groups on address bits 8-6
	localparam logic [2:0] GRP_MODEM = 3'h0;
	localparam logic [2:0] GRP_DMA = 3'h1;
	localparam logic [2:0] GRP_ETH = 3'h2;
	localparam logic [2:0] GRP_SERIAL = 3'h4;
	localparam logic [2:0] GRP_STATUS = 3'h5;
	localparam logic [2:0] GRP_ROM = 3'h6;
	localparam logic [2:0] GRP_ID = 3'h7;
	localparam int GRP_MSB = 8;
	localparam int GRP_LSB = 6;
	// sub-addresses inside groups
	localparam logic [1:0] DMA_RX_LENGTH = 2'h3;
	localparam logic [1:0] ETH_STATUS_HI = 2'h3;
	// status word field positions
	localparam int SEND_OUT_LSB = 24;
	localparam int RECV_OUT_LSB = 16;
	localparam int CONSUME_LSB = 12;
	localparam int PRODUCE_LSB = 8;
	localparam int CTRL_LSB = 4;
	localparam int CTRL_MSB = 7;
	// control bits inside the 4-bit field
	localparam int LANE_SEQ_BIT = 3;
	localparam int XCVR_ON_BIT = 2;
	localparam int SEND_EN_BIT = 1;
	localparam int RECV_EN_BIT = 0;
	// flag bits
	localparam int SEND_DONE_BIT = 3;
	localparam int RECV_DONE_BIT = 2;
	localparam int BUS_CHECK_BIT = 1;
	localparam int SERIAL_BIT = 0;
	// reset values
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [3:0] PTR_RESET = 4'h0;
	localparam logic [7:0] MODEM_RESET = 8'h00;
	// serial controller access spacing kept by the host
	localparam int SERIAL_GAP_NS = 450;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SERIAL_GAP_CYC =
		(SERIAL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// rom layout
	localparam int ROM_BYTES = 32;
	localparam logic [7:0] ROM_TEST0 = 8'hff;
	localparam logic [7:0] ROM_TEST1 = 8'h00;
	localparam logic [7:0] ROM_TEST2 = 8'h55;
	localparam logic [7:0] ROM_TEST3 = 8'haa;
endpackage

// *** rtl/station_address_rom.sv ***
// 32-byte station address rom, built from parameters
`timescale 1ns/1ps
module station_address_rom
	import net_adaptor_pkg::*;
#(
	// arbitrary neutral address and checksum
	parameter logic [47:0] STATION = 48'h0200_0000_0001,
	parameter logic [15:0] CHECKSUM = 16'h0000
)
(
	input wire logic [4:0] index,
	output logic [7:0] data
);
	logic [7:0] image [0:7];
	logic [7:0] table_q [0:ROM_BYTES-1];

	// first eight bytes: address then checksum
	always_comb
	begin
		for (int i = 0; i < 6; i++)
			image[i] = STATION[8*(5-i) +: 8];
		image[6] = CHECKSUM[15:8];
		image[7] = CHECKSUM[7:0];
	end

	// reversed copy, duplicate copy, then test pattern
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_fill
			assign table_q[g] = image[g]; // R4
			assign table_q[8+g] = image[7-g]; // R4
			assign table_q[16+g] = image[g]; // R4
			assign table_q[24+g] = (g % 4 == 0) ? ROM_TEST0 :
				(g % 4 == 1) ? ROM_TEST1 :
				(g % 4 == 2) ? ROM_TEST2 : ROM_TEST3; // R4
		end
	endgenerate

	assign data = table_q[index]; // R3
endmodule

// *** rtl/network_adaptor_io_registers.sv ***
// i/o register decode, status and control of the network adaptor
`timescale 1ns/1ps
module network_adaptor_io_registers
	import net_adaptor_pkg::*;
#(
	// arbitrary identifier value
	parameter logic [31:0] ID_CODE = 32'h0000_00a5
)
(
	input wire logic mclk,
	input wire logic nrst,
	// system i/o bus
	input wire logic io_read,
	input wire logic io_write,
	input wire logic [8:0] io_addr,
	input wire logic io_apar,
	input wire logic [31:0] io_wdata,
	input wire logic [3:0] io_wpar,
	output logic io_ack,
	output logic [31:0] io_rdata,
	output logic [3:0] io_rpar,
	output logic io_irq,
	// sub-device access port
	output logic [5:0] sub_addr,
	output logic [31:0] sub_wdata,
	output logic serial_rd,
	output logic serial_wr,
	output logic eth_rd,
	output logic eth_wr,
	output logic dma_rd,
	output logic dma_wr,
	input wire logic [7:0] serial_rdata,
	input wire logic [7:0] eth_rdata,
	input wire logic [31:0] dma_rdata,
	// pins from the controllers
	input wire logic serial_irq_pin,
	input wire logic eth_irq_pin,
	input wire logic [7:0] eth_send_live,
	input wire logic [7:0] eth_recv_live,
	// events from the dma sequencer
	input wire logic send_finished,
	input wire logic recv_status_stored,
	input wire logic dma_par_err,
	// controls to the rest of the adaptor
	output logic [7:0] modem_ctl,
	output logic lane_sequence_select,
	output logic loopback,
	output logic send_go,
	output logic recv_go,
	output logic [3:0] receive_consume_pointer,
	output logic [3:0] receive_produce_pointer,
	output logic fifo_empty,
	output logic fifo_full,
	output logic [11:0] recv_end_status
);

	////////////////////////////////////////////////////////////////
	// declarations

	logic [3:0] ctrl;
	logic [3:0] flags;
	logic [3:0] next_flags;
	logic [7:0] send_outcome_flags;
	logic [7:0] receive_outcome_flags;
	logic [3:0] next_produce;
	logic [3:0] next_consume;
	logic acc_rd;
	logic acc_wr;
	logic [2:0] acc_grp;
	logic [5:0] acc_low;
	logic [31:0] status_snap;
	logic [31:0] next_rdata;
	logic [7:0] rom_byte;
	logic [2:0] sync_q [0:1];
	logic [1:0] pin_level;
	logic eth_irq_seen;
	logic send_waiting;
	logic recv_flag_due;
	logic [2:0] grp;
	logic taken;
	logic take_rd;
	logic take_wr;
	logic status_clear;
	logic snap_now;
	logic par_bad;
	logic [3:0] set_vec;
	logic [31:0] status_now;

	////////////////////////////////////////////////////////////////
	// request decode

	// only one access in flight; stage one must be free
	assign grp = io_addr[GRP_MSB:GRP_LSB]; // R1
	assign taken = (io_read | io_write) & ~(acc_rd | acc_wr);
	assign take_rd = taken & io_read;
	assign take_wr = taken & io_write & ~io_read;

	// bit zero set on the read keeps flags pending
	assign status_clear = take_rd & (grp == GRP_STATUS) & ~io_addr[0]; // R17

	// status registers live in the top two ethernet offsets
	assign snap_now = (take_rd & (grp == GRP_ETH) &
		(io_addr[2:1] == ETH_STATUS_HI)) |
		(pin_level[1] & ~eth_irq_seen); // R8

	// odd parity per byte on writes, on the address for reads
	function automatic logic odd_bad(input logic [8:0] v);
		odd_bad = ~(^v);
	endfunction

	always_comb
	begin
		par_bad = 1'b0;
		if (take_wr)
		begin
			for (int b = 0; b < 4; b++)
				par_bad = par_bad |
					odd_bad({io_wdata[8*b +: 8], io_wpar[b]}); // R21
		end
		else if (take_rd)
			par_bad = odd_bad({io_addr[7:0], io_apar ^ io_addr[8]}); // R21
	end

	////////////////////////////////////////////////////////////////
	// pin synchronisers

	// three stages; a change counts once stages two and three agree
	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : g_sync
			always_ff @(posedge mclk)
			begin
				if (!nrst)
				begin
					sync_q[p] <= 3'h0;
					pin_level[p] <= 1'b0;
				end
				else
				begin
					sync_q[p] <= {sync_q[p][1:0],
						p == 0 ? serial_irq_pin : eth_irq_pin};
					if (sync_q[p][1] == sync_q[p][2])
						pin_level[p] <= sync_q[p][2];
				end
			end
		end
	endgenerate

	// edge memory for the ethernet interrupt
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			eth_irq_seen <= 1'b0;
		else
			eth_irq_seen <= pin_level[1];
	end

	////////////////////////////////////////////////////////////////
	// access pipeline

	// stage one: capture request and issue sub-device strobes
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			acc_rd <= 1'b0;
			acc_wr <= 1'b0;
			acc_grp <= GRP_MODEM;
			acc_low <= 6'h00;
			sub_addr <= 6'h00;
			sub_wdata <= 32'h0000_0000;
			serial_rd <= 1'b0;
			serial_wr <= 1'b0;
			eth_rd <= 1'b0;
			eth_wr <= 1'b0;
			dma_rd <= 1'b0;
			dma_wr <= 1'b0;
		end
		else
		begin
			acc_rd <= take_rd;
			acc_wr <= take_wr;
			if (taken)
			begin
				acc_grp <= grp; // R1
				acc_low <= io_addr[5:0]; // R1
				sub_addr <= io_addr[5:0];
			end
			if (take_wr)
			begin
				// byte-wide devices see only the low byte
				sub_wdata <= (grp == GRP_DMA) ? io_wdata :
					{24'h00_0000, io_wdata[7:0]}; // R5
			end
			serial_rd <= take_rd & (grp == GRP_SERIAL); // R5
			serial_wr <= take_wr & (grp == GRP_SERIAL); // R5
			eth_rd <= take_rd & (grp == GRP_ETH);
			eth_wr <= take_wr & (grp == GRP_ETH);
			dma_rd <= take_rd & (grp == GRP_DMA);
			dma_wr <= take_wr & (grp == GRP_DMA);
		end
	end

	// status word picture, caught before the read clears flags
	assign status_now = {send_outcome_flags, receive_outcome_flags,
		receive_consume_pointer, receive_produce_pointer,
		ctrl, flags}; // R23

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			status_snap <= 32'h0000_0000;
		else if (take_rd && grp == GRP_STATUS)
			status_snap <= status_now; // R7
	end

	station_address_rom station_address_rom_inst
	(
		.index(acc_low[4:0]),
		.data(rom_byte)
	);

	// stage two read mux; unmapped and write-only groups read zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (acc_grp)
			GRP_ID: next_rdata = ID_CODE; // R2
			GRP_ROM: next_rdata = {24'h00_0000, rom_byte}; // R3
			GRP_STATUS: next_rdata = status_snap; // R7
			GRP_SERIAL: next_rdata = {24'h00_0000, serial_rdata}; // R5
			GRP_ETH: next_rdata = {24'h00_0000, eth_rdata};
			GRP_DMA: next_rdata = dma_rdata;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// stage two: answer with data and generated parity
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			io_ack <= 1'b0;
			io_rdata <= 32'h0000_0000;
			io_rpar <= 4'hf;
		end
		else
		begin
			io_ack <= acc_rd | acc_wr; // R2
			io_rdata <= acc_rd ? next_rdata : 32'h0000_0000;
			for (int b = 0; b < 4; b++)
				io_rpar[b] <= acc_rd ? ~(^next_rdata[8*b +: 8])
					: 1'b1; // R21
		end
	end

	////////////////////////////////////////////////////////////////
	// control and modem registers

	// only the control field takes a status-group write
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			ctrl <= CTRL_RESET; // R11
		else if (take_wr && grp == GRP_STATUS)
			ctrl <= io_wdata[CTRL_MSB:CTRL_LSB]; // R7
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			modem_ctl <= MODEM_RESET;
		else if (take_wr && grp == GRP_MODEM)
			modem_ctl <= io_wdata[7:0]; // R1
	end

	////////////////////////////////////////////////////////////////
	// ethernet status holding registers

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			send_outcome_flags <= 8'h00;
			receive_outcome_flags <= 8'h00;
		end
		else if (snap_now)
		begin
			send_outcome_flags <= eth_send_live; // R8
			receive_outcome_flags <= eth_recv_live; // R8
		end
	end

	////////////////////////////////////////////////////////////////
	// descriptor fifo pointers

	// 4-bit pointers wrap modulo 16 by width
	assign next_consume = receive_consume_pointer +
		{3'h0, recv_status_stored}; // R9
	assign next_produce = receive_produce_pointer +
		{3'h0, take_wr && grp == GRP_DMA &&
		io_addr[1:0] == DMA_RX_LENGTH}; // R9

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			receive_consume_pointer <= PTR_RESET;
			receive_produce_pointer <= PTR_RESET;
			fifo_empty <= 1'b1;
			fifo_full <= 1'b0;
		end
		else
		begin
			receive_consume_pointer <= next_consume; // R9
			receive_produce_pointer <= next_produce; // R9
			fifo_empty <= next_consume == next_produce; // R10
			fifo_full <= 4'(next_produce + 4'h1) == next_consume; // R10
		end
	end

	// ending status carries the already advanced consume pointer
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			recv_end_status <= 12'h000;
		else
			recv_end_status <= {next_consume, receive_outcome_flags}; // R8
	end

	////////////////////////////////////////////////////////////////
	// transmitter and receiver gating

	// one packet per enable; rearm needs enable low first
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			send_waiting <= 1'b0;
			send_go <= 1'b0;
		end
		else
		begin
			if (!ctrl[SEND_EN_BIT])
				send_waiting <= 1'b0; // R14
			else if (send_finished)
				send_waiting <= 1'b1; // R14
			send_go <= ctrl[SEND_EN_BIT] & ~send_waiting &
				~send_finished; // R14
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			recv_go <= 1'b0;
			lane_sequence_select <= 1'b0;
			loopback <= 1'b1;
		end
		else
		begin
			recv_go <= ctrl[RECV_EN_BIT] &
				(next_consume != next_produce); // R15
			lane_sequence_select <= ctrl[LANE_SEQ_BIT]; // R12
			loopback <= ~ctrl[XCVR_ON_BIT]; // R13
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt flags

	// receive flag follows the pointer step by one cycle
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			recv_flag_due <= 1'b0;
		else
			recv_flag_due <= recv_status_stored; // R9
	end

	// sources; the serial one is a level, so it wins while active
	always_comb
	begin
		set_vec = 4'h0;
		set_vec[SEND_DONE_BIT] = send_finished; // R18
		set_vec[RECV_DONE_BIT] = recv_flag_due; // R20
		set_vec[BUS_CHECK_BIT] = par_bad | dma_par_err; // R21
		set_vec[SERIAL_BIT] = pin_level[0]; // R22
	end

	// set beats clear so a same-cycle event is kept
	assign next_flags = (flags & ~{4{status_clear}}) | set_vec; // R17

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			flags <= FLAGS_RESET; // R17
			io_irq <= 1'b0;
		end
		else
		begin
			flags <= next_flags; // R20
			io_irq <= |next_flags; // R16
		end
	end
endmodule

// *** dv/net_adaptor_monitor.sv ***
// concurrent checks on the adaptor register block ports
`timescale 1ns/1ps
module net_adaptor_monitor
	import net_adaptor_pkg::*;
#(
	parameter logic [31:0] ID_CODE = 32'h0000_00a5
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic io_read,
	input wire logic io_write,
	input wire logic [8:0] io_addr,
	input wire logic io_ack,
	input wire logic [31:0] io_rdata,
	input wire logic [3:0] io_rpar,
	input wire logic io_irq,
	input wire logic serial_rd,
	input wire logic serial_irq_pin,
	input wire logic send_finished,
	input wire logic recv_status_stored,
	input wire logic send_go,
	input wire logic [3:0] receive_consume_pointer,
	input wire logic [3:0] receive_produce_pointer,
	input wire logic fifo_empty,
	input wire logic fifo_full
);
	logic stage;
	logic take;
	// one access in flight; a request in the busy cycle is dropped
	assign take = (io_read | io_write) & ~stage;
	always_ff @(posedge mclk)
		stage <= nrst & take;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	sequence s_rd(g);
		take && io_read && io_addr[8:6] == g;
	endsequence
	sequence s_len_wr;
		take && io_write && io_addr[8:6] == GRP_DMA &&
			io_addr[1:0] == DMA_RX_LENGTH;
	endsequence
	a_ack_two_later:
		assert property (take |-> ##1 !io_ack ##1 io_ack)
		else $error("ack not two cycles after request");
	a_ident_read:
		assert property (s_rd(GRP_ID) |-> ##2 io_rdata == ID_CODE)
		else $error("identifier read wrong");
	a_serial_byte:
		assert property (s_rd(GRP_SERIAL) |->
			##1 serial_rd ##1 io_rdata[31:8] == 24'h0)
		else $error("serial read mapping wrong");
	a_rd_parity:
		assert property (io_rpar == {~^io_rdata[31:24],
			~^io_rdata[23:16], ~^io_rdata[15:8], ~^io_rdata[7:0]})
		else $error("read parity not odd");
	a_serial_irq:
		assert property (serial_irq_pin [*8] |-> io_irq)
		else $error("serial pin did not raise irq");
	a_send_stop:
		assert property (send_finished |-> ##[1:2] !send_go)
		else $error("send stayed armed after finish");
	a_event_irq:
		assert property (send_finished || recv_status_stored
			|-> ##[1:4] io_irq)
		else $error("event did not raise irq");
	a_consume_step:
		assert property (recv_status_stored |-> ##2
			receive_consume_pointer ==
			$past(receive_consume_pointer, 2) + 4'h1)
		else $error("consume pointer did not step");
	a_produce_step:
		assert property (s_len_wr |-> ##2 receive_produce_pointer ==
			$past(receive_produce_pointer, 2) + 4'h1)
		else $error("produce pointer did not step");
	// flags are registered from the next pointers, so they line up
	// with the pointers of the same cycle
	a_fifo_flags:
		assert property (fifo_empty == (receive_consume_pointer
			== receive_produce_pointer) && fifo_full ==
			(4'(receive_produce_pointer + 4'h1) ==
			receive_consume_pointer))
		else $error("fifo flags wrong");
	a_reset_clear:
		assert property ($rose(nrst) |-> !send_go && !io_irq)
		else $error("reset left control or irq set");
endmodule

// *** dv/sub_device_model.sv ***
// behavioural serial, ethernet and dma register responders
`timescale 1ns/1ps
module sub_device_model
(
	input wire logic mclk,
	input wire logic [5:0] sub_addr,
	input wire logic serial_rd,
	input wire logic eth_rd,
	input wire logic dma_rd,
	output logic [7:0] serial_rdata,
	output logic [7:0] eth_rdata,
	output logic [31:0] dma_rdata
);
	logic [7:0] junk;
	// unselected data flips each cycle so stale values never pass
	initial junk = 8'h00;
	always @(posedge mclk)
		junk <= ~junk;
	// answers carry the register index so the mapping shows
	assign serial_rdata = serial_rd ? {2'b10, sub_addr} : junk;
	assign eth_rdata = eth_rd ? {2'b01, sub_addr} : junk;
	assign dma_rdata = dma_rd ? {26'h0, sub_addr} : {4{junk}};
endmodule

// *** dv/network_adaptor_io_registers_tb_top.sv ***
// self-checking bench for the adaptor i/o register block
`timescale 1ns/1ps
module network_adaptor_io_registers_tb_top;
	import net_adaptor_pkg::*;
	localparam logic [31:0] ID = 32'h0000_0a5c; // arbitrary value
	logic mclk, nrst, io_read, io_write, io_apar, io_ack, io_irq;
	logic serial_rd, serial_wr, eth_rd, eth_wr, dma_rd, dma_wr;
	logic serial_irq_pin, eth_irq_pin, send_finished, dma_par_err;
	logic recv_status_stored, lane_sequence_select, loopback;
	logic send_go, recv_go, fifo_empty, fifo_full;
	logic [8:0] io_addr;
	logic [31:0] io_wdata, io_rdata, sub_wdata, dma_rdata, q;
	logic [3:0] io_wpar, io_rpar;
	logic [3:0] receive_consume_pointer, receive_produce_pointer;
	logic [5:0] sub_addr;
	logic [7:0] serial_rdata, eth_rdata, eth_send_live, eth_recv_live;
	logic [7:0] modem_ctl;
	logic [11:0] recv_end_status;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	network_adaptor_io_registers #(.ID_CODE(ID))
		network_adaptor_io_registers_inst (.*);
	sub_device_model sub_device_model_inst (.*);
	////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	// request drops after its taking edge so it is not taken twice
	task automatic bus(input logic wr, input logic [8:0] a,
		input logic [31:0] d, input logic bad);
		int n;
		@(negedge mclk);
		io_read = ~wr;
		io_write = wr;
		io_addr = a;
		io_apar = ~^a ^ bad;
		io_wdata = d;
		io_wpar = {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
		@(negedge mclk);
		io_read = 1'b0;
		io_write = 1'b0;
		n = 0;
		while (io_ack !== 1'b1 && n < 4)
		begin
			@(negedge mclk);
			n++;
		end
		q = io_rdata;
		chk("ack", 1'b1, io_ack);
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_ident;
		logic [7:0] r [32];
		logic [31:0] pat = 32'hff00_55aa;
		for (int i = 0; i < 32; i++)
		begin
			bus(1'b0, 9'h180 + 9'(i), 32'h0, 1'b0);
			r[i] = q[7:0];
			chk("rom_hi", 32'h0, {8'h0, q[31:8]});
		end
		for (int i = 0; i < 8; i++)
		begin
			chk("rom_pat", pat[31 - 8 * (i % 4) -: 8], r[24 + i]);
			chk("rom_rev", r[7 - i], r[8 + i]);
			chk("rom_dup", r[i], r[16 + i]);
		end
		bus(1'b1, 9'h185, 32'h0000_00ff, 1'b0);
		bus(1'b0, 9'h185, 32'h0, 1'b0);
		chk("rom_wr", r[5], q);
		bus(1'b1, 9'h1c0, 32'hffff_ffff, 1'b0);
		bus(1'b0, 9'h1ff, 32'h0, 1'b0);
		chk("ident", ID, q);
		$display("t_ident done");
	endtask
	task automatic t_control;
		chk("loop_rst", 1'b1, loopback);
		bus(1'b0, 9'h141, 32'h0, 1'b0);
		chk("status_rst", 32'h0, q[15:0]);
		bus(1'b1, 9'h140, 32'hffff_fff0, 1'b0);
		@(negedge mclk);
		chk("lane", 1'b1, lane_sequence_select);
		chk("loopback", 1'b0, loopback);
		chk("send_go", 1'b1, send_go);
		chk("recv_go", 1'b0, recv_go);
		bus(1'b0, 9'h141, 32'h0, 1'b0);
		chk("ro_fields", 32'h00f0, q[15:0]);
		$display("t_control done");
	endtask
	task automatic t_send;
		pulse(send_finished);
		repeat (3) @(negedge mclk);
		chk("send_go", 1'b0, send_go);
		chk("irq", 1'b1, io_irq);
		bus(1'b0, 9'h141, 32'h0, 1'b0);
		chk("keep", 32'h8, q[3:0]);
		bus(1'b0, 9'h140, 32'h0, 1'b0);
		chk("flags", 32'h8, q[3:0]);
		@(negedge mclk);
		chk("irq_off", 1'b0, io_irq);
		bus(1'b1, 9'h140, 32'h0000_00d0, 1'b0);
		bus(1'b1, 9'h140, 32'h0000_00f0, 1'b0);
		@(negedge mclk);
		chk("rearm", 1'b1, send_go);
		$display("t_send done");
	endtask
	task automatic t_fifo;
		chk("empty", 1'b1, fifo_empty);
		chk("recv_idle", 1'b0, recv_go);
		for (int i = 0; i < 15; i++)
			bus(1'b1, 9'h043, 32'h0000_0100, 1'b0);
		@(negedge mclk);
		chk("full", 1'b1, fifo_full);
		chk("not_empty", 1'b0, fifo_empty);
		chk("recv_go", 1'b1, recv_go);
		pulse(recv_status_stored);
		repeat (2) @(negedge mclk);
		pulse(recv_status_stored);
		repeat (3) @(negedge mclk);
		chk("not_full", 1'b0, fifo_full);
		chk("end_status", 32'h200, recv_end_status);
		bus(1'b0, 9'h140, 32'h0, 1'b0);
		chk("ptrs_flags", 32'h2f4, {q[15:8], q[3:0]});
		$display("t_fifo done");
	endtask
	task automatic t_serial;
		bus(1'b0, 9'h105, 32'h0, 1'b0);
		chk("serial", 32'h0000_0085, q);
		repeat (10) @(negedge mclk);
		bus(1'b1, 9'h105, 32'hffff_ff3c, 1'b0);
		chk("serial_wdata", 32'h0000_003c, sub_wdata);
		serial_irq_pin = 1'b1;
		repeat (8) @(negedge mclk);
		bus(1'b0, 9'h140, 32'h0, 1'b0);
		chk("pin_set", 1'b1, q[0]);
		serial_irq_pin = 1'b0;
		repeat (8) @(negedge mclk);
		bus(1'b0, 9'h140, 32'h0, 1'b0);
		chk("held", 1'b1, q[0]);
		bus(1'b0, 9'h141, 32'h0, 1'b0);
		chk("cleared", 32'h0, q[3:0]);
		$display("t_serial done");
	endtask
	task automatic t_misc;
		bus(1'b0, 9'h1c0, 32'h0, 1'b1);
		bus(1'b0, 9'h140, 32'h0, 1'b0);
		chk("parity", 32'h2, q[3:0]);
		eth_send_live = 8'h3c;
		eth_recv_live = 8'h5a;
		bus(1'b0, 9'h086, 32'h0, 1'b0);
		chk("eth", 32'h0000_0046, q);
		eth_send_live = 8'h00;
		eth_recv_live = 8'h00;
		bus(1'b0, 9'h141, 32'h0, 1'b0);
		chk("snapshot", 32'h3c5a, q[31:16]);
		// controller interrupt pin must catch the live status too
		eth_send_live = 8'h96;
		eth_recv_live = 8'h69;
		eth_irq_pin = 1'b1;
		repeat (6) @(negedge mclk);
		eth_irq_pin = 1'b0;
		eth_send_live = 8'h00;
		eth_recv_live = 8'h00;
		bus(1'b0, 9'h141, 32'h0, 1'b0);
		chk("pin_snap", 32'h9669, q[31:16]);
		bus(1'b0, 9'h0c0, 32'h0, 1'b0);
		chk("unused", 32'h0, q);
		$display("t_misc done");
	endtask
	// second reset in mid-run with control, flags and pointers set
	task automatic t_reset;
		bus(1'b1, 9'h000, 32'h0000_005a, 1'b0);
		chk("modem", 32'h5a, modem_ctl);
		serial_irq_pin = 1'b1;
		repeat (8) @(negedge mclk);
		chk("irq_pre", 1'b1, io_irq);
		nrst = 1'b0;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		serial_irq_pin = 1'b0;
		chk("rst_irq", 1'b0, io_irq);
		chk("rst_send", 1'b0, send_go);
		chk("rst_loop", 1'b1, loopback);
		chk("rst_empty", 1'b1, fifo_empty);
		chk("rst_modem", 32'h0, modem_ctl);
		bus(1'b0, 9'h141, 32'h0, 1'b0);
		chk("rst_status", 32'h0, q[15:0]);
		$display("t_reset done");
	endtask
	////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// cut a hang short well past the expected run length
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			conclude;
		end
	end
	initial
	begin
		{nrst, io_read, io_write, io_apar, serial_irq_pin} = '0;
		{eth_irq_pin, send_finished, recv_status_stored} = '0;
		dma_par_err = 1'b0;
		io_addr = '0;
		io_wdata = '0;
		io_wpar = '0;
		eth_send_live = '0;
		eth_recv_live = '0;
		repeat (6) @(negedge mclk);
		nrst = 1'b1;
		t_control;
		t_ident;
		t_send;
		t_fifo;
		t_serial;
		t_misc;
		t_reset;
		conclude;
	end
endmodule
bind network_adaptor_io_registers net_adaptor_monitor
	#(.ID_CODE(ID_CODE)) net_adaptor_monitor_inst (.*);
